/* File: hdl/acg_pkg.sv */
// constants and types for the auxiliary clock generator
package acg_pkg;

    // ********************************
    // clock rates
    // ********************************
    localparam int unsigned MCLK_KHZ = 20000;
    localparam int unsigned TICK_KHZ = 256;
    localparam logic [14:0] ACC_STEP = 15'(TICK_KHZ);
    localparam logic [14:0] ACC_WRAP = 15'(MCLK_KHZ - TICK_KHZ);
    localparam logic [14:0] ACC_BACK = 15'(MCLK_KHZ);

    // ********************************
    // bus geometry and answers
    // ********************************
    localparam int unsigned ADDR_W  = 8;
    localparam int unsigned IDX_W   = 6;
    localparam logic [1:0]  RESP_OK = 2'h0;
    localparam logic [1:0]  RESP_ER = 2'h2;

    // ********************************
    // register indices, byte address = 4 x index
    // ********************************
    localparam logic [5:0] IDX_TOSCALE = 6'h14;
    localparam logic [5:0] IDX_RATES   = 6'h15;
    localparam logic [5:0] IDX_CLKEN   = 6'h16;
    localparam logic [5:0] IDX_AIF2    = 6'h1a;
    localparam logic [5:0] IDX_PINFN   = 6'h30;
    localparam logic [5:0] IDX_STATUS  = 6'h31;

    // ********************************
    // field positions
    // ********************************
    localparam int unsigned B_DIV16   = 14;
    localparam int unsigned B_X4      = 13;
    localparam int unsigned B_RATE    = 12;
    localparam int unsigned B_OPEN    = 3;
    localparam int unsigned B_SYSEN   = 2;
    localparam int unsigned B_TOEN    = 0;
    localparam int unsigned B_PINSEL  = 0;
    localparam int unsigned F_OPDIV   = 8;
    localparam int unsigned F_RATIO   = 10;
    localparam int unsigned F_SRATE   = 0;
    localparam int unsigned S_OPLVL   = 0;
    localparam int unsigned S_TOLVL   = 1;
    localparam int unsigned S_OPRUN   = 2;
    localparam int unsigned S_FAM48   = 3;
    localparam int unsigned S_R128    = 4;
    localparam int unsigned S_OPDIV   = 8;

    // ********************************
    // reset values and codes
    // ********************************
    localparam logic [3:0] RATIO_RST  = 4'h3;
    localparam logic [3:0] RATIO_128  = 4'h1;
    localparam logic [2:0] SR_RST     = 3'h5;
    localparam logic [2:0] SR_48K     = 3'h5;
    localparam logic [3:0] OP_DIV1    = 4'h0;
    localparam logic [3:0] OP_DIV_5P5 = 4'h4;
    localparam logic [3:0] OP_DIV_MAX = 4'h8;
    localparam logic [4:0] OP_PER [9] = '{5'h01, 5'h02, 5'h03, 5'h04,
        5'h05, 5'h06, 5'h08, 5'h0c, 5'h10};
    localparam logic [4:0] OP_P55_LO  = 5'h05;
    localparam logic [4:0] OP_P55_HI  = 5'h06;
    localparam logic [14:0] TO_HALF_MIN = 15'h0080;
    localparam logic [14:0] TO_HALF_MAX = 15'h4000;
    localparam logic [14:0] TO_HALF_RST = 15'h0400;

    // ********************************
    // carriers
    // ********************************
    typedef struct packed {
        logic              awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic              wvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [ADDR_W-1:0] araddr;
        logic              rready;
    } acg_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } acg_axi_rsp_t;

    typedef struct packed {
        logic             aw_have;
        logic [IDX_W-1:0] aw_idx;
        logic             w_have;
        logic [15:0]      w_data;
        logic [1:0]       w_strb;
        logic             b_valid;
        logic [1:0]       b_resp;
        logic             r_valid;
        logic [15:0]      r_data;
        logic [1:0]       r_resp;
        logic             to_d16;
        logic             to_x4;
        logic             to_rate;
        logic             gpio_en;
        logic             sys_en;
        logic             to_en;
        logic [3:0]       ratio;
        logic [2:0]       srate;
        logic [3:0]       op_sel;
        logic             pin_sel;
        logic [3:0]       op_div;
        logic [4:0]       op_cnt;
        logic             op_alt;
        logic             op_lvl;
        logic             op_run;
        logic [14:0]      acc;
        logic [14:0]      to_cnt;
        logic [14:0]      to_half;
        logic             to_lvl;
        logic             to_tick;
    } acg_state_t;

endpackage : acg_pkg

/* File: hdl/acg_top.sv */
// auxiliary clock generator: gpio clock output and timeout clock
//
// What this block does
// - gpio clock output runs only while its enable bit is set; reset off.
// - divider field picks 1,2,3,4,5.5,6,8,12,16; codes above 1000 reserved.
// - pin is driven only when the pin function selects this clock.
// - timeout clock comes from a 256kHz base, only while enabled.
// - timeout clock is the time base for debounce and volume timeout.
// - rate bit zero halves the timeout clock, one leaves it.
// - divide-by-16 bit one divides the timeout clock by sixteen.
// - times-four bit one multiplies the timeout clock by four.
// - timeout periods span 1 ms to 128 ms, doubling per step.
// - rate code 101 is the 48k family, ratio code 0001 is 128.
// - system clock, source of the gpio clock, runs only when enabled.
`timescale 1ns/1ps
module acg_top
    import acg_pkg::*;
(
    // clock and reset
    input  wire logic         mclk_i,
    input  wire logic         arst_n_i,
    // register bus
    input  wire acg_axi_req_t axi_req_i,
    output acg_axi_rsp_t      axi_rsp_o,
    // generated clocks
    output logic              gpio_clock_out_o,
    output logic              timeout_clock_o,
    output logic              timeout_tick_o,
    output logic              system_clock_run_o,
    // gpio pin
    output logic              gpio_pin_o,
    output logic              gpio_pin_oe_o
);

    // ********************************
    // helpers
    // ********************************
    function automatic logic [15:0] reg_rd(acg_state_t s,
                                           logic [IDX_W-1:0] idx);
        logic [15:0] v;
        v = '0;
        unique case (idx)
            IDX_TOSCALE: begin
                v[B_DIV16] = s.to_d16;
                v[B_X4]    = s.to_x4;
            end
            IDX_RATES: begin
                v[F_RATIO+:4] = s.ratio;
                v[F_SRATE+:3] = s.srate;
            end
            IDX_CLKEN: begin
                v[B_RATE]  = s.to_rate;
                v[B_OPEN]  = s.gpio_en;
                v[B_SYSEN] = s.sys_en;
                v[B_TOEN]  = s.to_en;
            end
            IDX_AIF2:  v[F_OPDIV+:4] = s.op_sel;
            IDX_PINFN: v[B_PINSEL] = s.pin_sel;
            IDX_STATUS: begin
                v[S_OPLVL]    = s.op_lvl;
                v[S_TOLVL]    = s.to_lvl;
                v[S_OPRUN]    = s.op_run;
                v[S_FAM48]    = (s.srate == SR_48K);
                v[S_R128]     = (s.ratio == RATIO_128);
                v[S_OPDIV+:4] = s.op_div;
            end
            default: v = '0;
        endcase
        return v;
    endfunction : reg_rd

    function automatic logic reg_hit(logic [IDX_W-1:0] idx);
        return idx inside {IDX_TOSCALE, IDX_RATES, IDX_CLKEN,
                           IDX_AIF2, IDX_PINFN, IDX_STATUS};
    endfunction : reg_hit

    function automatic logic [14:0] to_half_f(logic rate, logic x4,
                                              logic d16);
        return TO_HALF_MIN << {d16, ~x4, ~rate};
    endfunction : to_half_f

    // ********************************
    // state
    // ********************************
    localparam acg_state_t ST_RST = '{ratio: RATIO_RST, srate: SR_RST,
        to_half: TO_HALF_RST, default: '0};

    acg_state_t q;
    acg_state_t d;

    always_comb begin
        logic [15:0] wv;
        logic [3:0]  div_now;
        logic [4:0]  per;
        logic        tick;
        logic        run;
        wv      = '0;
        div_now = q.op_div;
        per     = '0;
        tick    = 1'b0;
        run     = q.gpio_en && q.sys_en;
        d       = q;

        // ********************************
        // bus write
        // ********************************
        if (axi_req_i.awvalid && !q.aw_have && !q.b_valid) begin
            d.aw_have = 1'b1;
            d.aw_idx  = axi_req_i.awaddr[ADDR_W-1:2];
        end
        if (axi_req_i.wvalid && !q.w_have && !q.b_valid) begin
            d.w_have = 1'b1;
            d.w_data = axi_req_i.wdata[15:0];
            d.w_strb = axi_req_i.wstrb[1:0];
        end
        if (q.aw_have && q.w_have) begin
            d.aw_have = 1'b0;
            d.w_have  = 1'b0;
            d.b_valid = 1'b1;
            d.b_resp  = RESP_OK;
            wv = reg_rd(q, q.aw_idx);
            if (q.w_strb[0]) wv[7:0] = q.w_data[7:0];
            if (q.w_strb[1]) wv[15:8] = q.w_data[15:8];
            unique case (q.aw_idx)
                IDX_TOSCALE: begin
                    d.to_d16 = wv[B_DIV16];
                    d.to_x4  = wv[B_X4];
                end
                IDX_RATES: begin
                    d.ratio = wv[F_RATIO+:4];
                    d.srate = wv[F_SRATE+:3];
                end
                IDX_CLKEN: begin
                    d.to_rate = wv[B_RATE];
                    d.gpio_en = wv[B_OPEN];
                    d.sys_en  = wv[B_SYSEN];
                    d.to_en   = wv[B_TOEN];
                end
                IDX_AIF2:  d.op_sel = wv[F_OPDIV+:4];
                IDX_PINFN: d.pin_sel = wv[B_PINSEL];
                default:   d.b_resp = RESP_ER;
            endcase
        end
        if (q.b_valid && axi_req_i.bready) begin
            d.b_valid = 1'b0;
        end

        // ********************************
        // bus read
        // ********************************
        if (axi_req_i.arvalid && !q.r_valid) begin
            d.r_valid = 1'b1;
            d.r_data  = reg_rd(q, axi_req_i.araddr[ADDR_W-1:2]);
            d.r_resp  = reg_hit(axi_req_i.araddr[ADDR_W-1:2]) ?
                        RESP_OK : RESP_ER;
        end else if (q.r_valid && axi_req_i.rready) begin
            d.r_valid = 1'b0;
        end

        // ********************************
        // gpio clock divider
        // ********************************
        d.op_run = run;
        if (!run) begin
            d.op_cnt = '0;
            d.op_lvl = 1'b0;
            d.op_alt = 1'b0;
        end else begin
            if (q.op_cnt == '0) begin
                if (q.op_sel <= OP_DIV_MAX) begin
                    div_now = q.op_sel;
                end
                d.op_div = div_now;
            end
            per = (q.op_alt && div_now == OP_DIV_5P5) ?
                  OP_P55_HI : OP_PER[div_now];
            d.op_lvl = (q.op_cnt < (per >> 1));
            if (q.op_cnt == per - 5'h01) begin
                d.op_cnt = '0;
                d.op_alt = ~q.op_alt;
            end else begin
                d.op_cnt = q.op_cnt + 5'h01;
            end
        end

        // ********************************
        // timeout clock
        // ********************************
        d.to_tick = 1'b0;
        if (!q.to_en) begin
            d.acc     = '0;
            d.to_cnt  = '0;
            d.to_lvl  = 1'b0;
            d.to_half = to_half_f(q.to_rate, q.to_x4, q.to_d16);
        end else begin
            if (q.acc >= ACC_WRAP) begin
                d.acc = q.acc + ACC_STEP - ACC_BACK;
                tick  = 1'b1;
            end else begin
                d.acc = q.acc + ACC_STEP;
            end
            if (tick) begin
                if (q.to_cnt == q.to_half - 15'h0001) begin
                    d.to_cnt = '0;
                    d.to_lvl = ~q.to_lvl;
                    if (!q.to_lvl) begin
                        d.to_tick = 1'b1;
                        d.to_half = to_half_f(q.to_rate, q.to_x4,
                                              q.to_d16);
                    end
                end else begin
                    d.to_cnt = q.to_cnt + 15'h0001;
                end
            end
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            q <= ST_RST;
        end else begin
            q <= d;
        end
    end

    // ********************************
    // outputs
    // ********************************
    always_comb begin
        axi_rsp_o         = '0;
        axi_rsp_o.awready = !q.aw_have && !q.b_valid;
        axi_rsp_o.wready  = !q.w_have && !q.b_valid;
        axi_rsp_o.bvalid  = q.b_valid;
        axi_rsp_o.bresp   = q.b_resp;
        axi_rsp_o.arready = !q.r_valid;
        axi_rsp_o.rvalid  = q.r_valid;
        axi_rsp_o.rdata   = {16'h0000, q.r_data};
        axi_rsp_o.rresp   = q.r_resp;
    end

    // divide by one passes the gated clock itself
    assign gpio_clock_out_o   = (q.op_run && q.op_div == OP_DIV1) ?
                                mclk_i : q.op_lvl;
    assign gpio_pin_o         = gpio_clock_out_o && q.pin_sel;
    assign gpio_pin_oe_o      = q.op_run && q.pin_sel;
    assign timeout_clock_o    = q.to_lvl;
    assign timeout_tick_o     = q.to_tick;
    assign system_clock_run_o = q.sys_en;

    // ********************************
    // checks
    // ********************************
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);

    sequence s_lo55;
        q.op_run && q.op_div == OP_DIV_5P5 && !q.op_alt
        && q.op_cnt == OP_P55_LO - 5'h01;
    endsequence
    sequence s_hi55;
        q.op_run && q.op_div == OP_DIV_5P5 && q.op_alt
        && q.op_cnt == OP_P55_HI - 5'h01;
    endsequence

    property p_gpio_off;
        !q.gpio_en |=> !gpio_clock_out_o;
    endproperty
    a_gpio_off: assert property (p_gpio_off)
        else $error("gpio clock active while disabled");

    property p_sys_off;
        !q.sys_en |=> !q.op_run && !gpio_clock_out_o;
    endproperty
    a_sys_off: assert property (p_sys_off)
        else $error("gpio clock active without system clock");

    property p_pin;
        gpio_pin_oe_o |-> q.pin_sel && $past(q.gpio_en) && $past(q.sys_en);
    endproperty
    a_pin: assert property (p_pin)
        else $error("pin driven without clock function");

    property p_div_hold;
        q.op_cnt != '0 |=> $stable(q.op_div);
    endproperty
    a_div_hold: assert property (p_div_hold)
        else $error("divider changed inside a period");

    property p_half55;
        s_lo55 ##1 (q.op_div == OP_DIV_5P5 && q.op_run)[*6]
        |-> s_hi55;
    endproperty
    a_half55: assert property (p_half55)
        else $error("divide by 5.5 not alternating 5 and 6");

    property p_lo55_wrap;
        s_lo55 ##1 q.op_run |-> q.op_cnt == '0 && q.op_alt;
    endproperty
    a_lo55_wrap: assert property (p_lo55_wrap)
        else $error("short 5.5 period not five cycles");

    property p_to_off;
        !q.to_en |=> !timeout_clock_o && q.to_cnt == '0;
    endproperty
    a_to_off: assert property (p_to_off)
        else $error("timeout clock active while disabled");

    property p_tick;
        timeout_tick_o |-> timeout_clock_o && $past(q.to_en)
        && q.to_half == to_half_f($past(q.to_rate), $past(q.to_x4),
                                  $past(q.to_d16));
    endproperty
    a_tick: assert property (p_tick)
        else $error("timeout tick with wrong rate");

    property p_half_range;
        q.to_half >= TO_HALF_MIN && q.to_half <= TO_HALF_MAX;
    endproperty
    a_half_range: assert property (p_half_range)
        else $error("timeout period out of range");

    property p_bresp;
        q.aw_have && q.w_have |=> q.b_valid;
    endproperty
    a_bresp: assert property (p_bresp)
        else $error("write response missing");

endmodule : acg_top

/* File: verif/acg_top_tb.sv */
// self-checking testbench for the auxiliary clock generator
`timescale 1ns/1ps
module acg_top_tb
    import acg_pkg::*;
;
    // ********************************
    // signals and tables
    // ********************************
    typedef struct {
        logic [7:0]  a;
        logic [31:0] wd;
        logic [1:0]  wr;
        logic [31:0] rd;
        logic [31:0] mk;
        logic [1:0]  rr;
    } acg_row_t;

    logic         mclk_i     = 1'b0;
    logic         arst_n_i   = 1'b0;
    acg_axi_req_t req        = '0;
    acg_axi_rsp_t rsp;
    logic         gpio_clk;
    logic         to_clk;
    logic         to_tick;
    logic         sys_run;
    logic         pin;
    logic         pin_oe;
    int           n_mismatch = 0;
    int           n_compared = 0;
    int           cyc        = 0;
    int           per2 [9]   = '{2, 4, 6, 8, 11, 12, 16, 24, 32};
    acg_row_t     rows [7]   = '{
        '{8'h50, 32'h6000, RESP_OK, 32'h6000, 32'hffff, RESP_OK},
        '{8'h54, 32'h0405, RESP_OK, 32'h0405, 32'hffff, RESP_OK},
        '{8'h58, 32'h100d, RESP_OK, 32'h100d, 32'hffff, RESP_OK},
        '{8'h68, 32'h0400, RESP_OK, 32'h0400, 32'hffff, RESP_OK},
        '{8'hc0, 32'h0001, RESP_OK, 32'h0001, 32'hffff, RESP_OK},
        '{8'hc4, 32'hffff, RESP_ER, 32'h0000, 32'h0000, RESP_OK},
        '{8'h04, 32'h0001, RESP_ER, 32'h0000, 32'hffff, RESP_ER}};
    acg_row_t     rst_rows [6] = '{
        '{8'h50, 32'h0, RESP_OK, 32'h0000, 32'hffff, RESP_OK},
        '{8'h54, 32'h0, RESP_OK, 32'h0c05, 32'hffff, RESP_OK},
        '{8'h58, 32'h0, RESP_OK, 32'h0000, 32'hffff, RESP_OK},
        '{8'h68, 32'h0, RESP_OK, 32'h0000, 32'hffff, RESP_OK},
        '{8'hc0, 32'h0, RESP_OK, 32'h0000, 32'hffff, RESP_OK},
        '{8'hc4, 32'h0, RESP_OK, 32'h0008, 32'h0f1f, RESP_OK}};

    acg_top acg_top_i (
        .mclk_i             (mclk_i),
        .arst_n_i           (arst_n_i),
        .axi_req_i          (req),
        .axi_rsp_o          (rsp),
        .gpio_clock_out_o   (gpio_clk),
        .timeout_clock_o    (to_clk),
        .timeout_tick_o     (to_tick),
        .system_clock_run_o (sys_run),
        .gpio_pin_o         (pin),
        .gpio_pin_oe_o      (pin_oe)
    );

    always #25 mclk_i = ~mclk_i;

    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    // ********************************
    // tasks
    // ********************************
    task automatic print_verdict();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        logic aw;
        logic w;
        aw = 1'b0;
        w  = 1'b0;
        @(posedge mclk_i);
        req.awvalid <= 1'b1;
        req.awaddr  <= a;
        req.wvalid  <= 1'b1;
        req.wdata   <= d;
        req.wstrb   <= 4'hf;
        req.bready  <= 1'b1;
        while (!(aw && w)) begin
            @(posedge mclk_i);
            if (!aw && rsp.awready === 1'b1) begin
                aw = 1'b1;
                req.awvalid <= 1'b0;
            end
            if (!w && rsp.wready === 1'b1) begin
                w = 1'b1;
                req.wvalid <= 1'b0;
            end
        end
        do @(posedge mclk_i); while (rsp.bvalid !== 1'b1);
        r = rsp.bresp;
        req.bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge mclk_i);
        req.arvalid <= 1'b1;
        req.araddr  <= a;
        req.rready  <= 1'b1;
        do @(posedge mclk_i); while (rsp.arready !== 1'b1);
        req.arvalid <= 1'b0;
        do @(posedge mclk_i); while (rsp.rvalid !== 1'b1);
        d = rsp.rdata;
        r = rsp.rresp;
        req.rready <= 1'b0;
    endtask : rd

    task automatic run_rows(input acg_row_t t [], input logic do_wr);
        logic [31:0] d;
        logic [1:0]  r;
        foreach (t[i]) begin
            if (do_wr) begin
                wr(t[i].a, t[i].wd, r);
                chk({30'h0, r}, {30'h0, t[i].wr});
            end
            rd(t[i].a, d, r);
            chk(d & t[i].mk, t[i].rd);
            chk({30'h0, r}, {30'h0, t[i].rr});
        end
    endtask : run_rows

    task automatic gper(output int p);
        time t0;
        @(posedge gpio_clk);
        @(posedge gpio_clk);
        t0 = $time;
        @(posedge gpio_clk);
        @(posedge gpio_clk);
        p = int'(($time - t0) / 50);
    endtask : gper

    task automatic hi_count(output int h);
        h = 0;
        repeat (40) begin
            @(negedge mclk_i);
            if (gpio_clk !== 1'b0 || pin_oe !== 1'b0) h++;
        end
    endtask : hi_count

    task automatic wtick();
        do @(posedge mclk_i); while (to_tick !== 1'b1);
    endtask : wtick

    // ********************************
    // main sequence
    // ********************************
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        int          p;
        int          c0;
        repeat (20) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        run_rows(rows, 1'b1);
        $display("test register rows done");
        wr(8'h54, 32'h0405, r);
        rd(8'hc4, d, r);
        chk(d & 32'h18, 32'h18);
        wr(8'h58, 32'h000c, r);
        wr(8'hc0, 32'h0001, r);
        for (int k = 0; k < 9; k++) begin
            wr(8'h68, 32'(k) << 8, r);
            gper(p);
            chk(32'(p), 32'(per2[k]));
            rd(8'hc4, d, r);
            chk((d >> 8) & 32'hf, 32'(k));
            chk({31'h0, pin_oe}, 32'h1);
        end
        wr(8'h68, 32'h0900, r);
        gper(p);
        chk(32'(p), 32'd32);
        rd(8'hc4, d, r);
        chk((d >> 8) & 32'hf, 32'h8);
        @(posedge gpio_clk);
        @(negedge mclk_i);
        chk({30'h0, pin, gpio_clk}, 32'h3);
        $display("test divider ratios done");
        wr(8'hc0, 32'h0000, r);
        repeat (4) @(posedge mclk_i);
        chk({30'h0, pin_oe, pin}, 32'h0);
        wr(8'h58, 32'h0004, r);
        repeat (4) @(posedge mclk_i);
        chk({31'h0, sys_run}, 32'h1);
        hi_count(p);
        chk(32'(p), 32'h0);
        wr(8'h58, 32'h0008, r);
        repeat (4) @(posedge mclk_i);
        chk({31'h0, sys_run}, 32'h0);
        hi_count(p);
        chk(32'(p), 32'h0);
        $display("test enables done");
        wr(8'h50, 32'h2000, r);
        wr(8'h58, 32'h1001, r);
        wtick();
        chk({31'h0, to_clk}, 32'h1);
        c0 = cyc;
        wtick();
        chk(32'(cyc - c0), 32'd20000);
        wr(8'h58, 32'h1000, r);
        repeat (4) @(posedge mclk_i);
        chk({30'h0, to_clk, to_tick}, 32'h0);
        $display("test timeout clock done");
        wr(8'h58, 32'h100d, r);
        @(posedge mclk_i);
        arst_n_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        chk({28'h0, gpio_clk, to_clk, sys_run, pin_oe}, 32'h0);
        repeat (17) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        run_rows(rst_rows, 1'b0);
        $display("test reset values done");
        print_verdict();
    end

endmodule : acg_top_tb
